/* src/sac_pkg.sv */
package sac_pkg;
   localparam int WORD_W = 6;
   localparam logic [5:0] REF_WORD = 6'h3f;
   localparam int MSB = 5;
   localparam int LSB = 0;
   // Power-up words, active low bits
   localparam logic [5:0] PUP_31P5 = 6'h00;
   localparam logic [5:0] PUP_24P0 = 6'h0f;
   localparam logic [5:0] PUP_16P0 = 6'h1f;
   localparam logic [5:0] PUP_0P0 = 6'h3f;
   localparam int CLK_MHZ = 25;
   localparam int PUP_DELAY_MS = 200;
   localparam int PUP_CYCLES = PUP_DELAY_MS * 1000 * CLK_MHZ;
   localparam logic [2:0] APB_ZERO = 3'h0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;
   localparam int CTRL_SOFT = 6;
   typedef enum logic [2:0] {
      ST_WAIT = 3'b001,
      ST_RUN = 3'b010,
      ST_SOFT = 3'b100
   } sac_state_e;
endpackage

/* src/sac_top.sv */
`timescale 1ns/1ns
module sac_top #(
   parameter int PUP_CYCLES = sac_pkg::PUP_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_mode,
   input wire logic shift_clk,
   input wire logic serial_word_in,
   input wire logic latch_strobe,
   input wire logic [5:0] parallel_weight_inputs,
   input wire logic powerup_select_a,
   input wire logic powerup_select_b,
   output logic serial_chain_out,
   output logic [5:0] atten_word,
   output logic atten_valid
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Pins are asynchronous; two flops before any logic reads them
   logic [10:0] s1_reg;
   logic [10:0] s2_reg;
   logic sclk_d_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 11'h000;
         s2_reg <= 11'h000;
         sclk_d_reg <= 1'b0;
      end else begin
         s1_reg <= {serial_mode, shift_clk, serial_word_in, latch_strobe,
                    parallel_weight_inputs, powerup_select_a};
         s2_reg <= s1_reg;
         sclk_d_reg <= s2_reg[9];
      end
   end
   logic sel_b1_reg;
   logic sel_b2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_b1_reg <= 1'b0;
         sel_b2_reg <= 1'b0;
      end else begin
         sel_b1_reg <= powerup_select_b;
         sel_b2_reg <= sel_b1_reg;
      end
   end
   logic mode_s;
   logic sclk_s;
   logic sdi_s;
   logic le_s;
   logic [5:0] par_s;
   logic pa_s;
   assign mode_s = s2_reg[10];
   assign sclk_s = s2_reg[9];
   assign sdi_s = s2_reg[8];
   assign le_s = s2_reg[7];
   assign par_s = s2_reg[6:1];
   assign pa_s = s2_reg[0];
   // Edge found on synced levels; each pin level must last three cycles
   logic sclk_rise;
   assign sclk_rise = sclk_s && !sclk_d_reg;
   logic le_d_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) le_d_reg <= 1'b0;
      else le_d_reg <= le_s;
   end
   logic le_rise;
   assign le_rise = le_s && !le_d_reg;

   // Power-up word picked by the two select pins
   function automatic logic [5:0] pup_word(input logic a, input logic b);
      case ({b, a})
         2'b00: pup_word = sac_pkg::PUP_31P5;
         2'b01: pup_word = sac_pkg::PUP_24P0;
         2'b10: pup_word = sac_pkg::PUP_16P0;
         default: pup_word = sac_pkg::PUP_0P0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Power-up sequencing
   // ------------------------------------------------------------
   sac_pkg::sac_state_e state_reg;
   logic [31:0] pup_cnt_reg;
   logic soft_req;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= sac_pkg::ST_WAIT;
         pup_cnt_reg <= 32'h0000_0000;
      end else begin
         case (state_reg)
            sac_pkg::ST_WAIT: begin
               if (pup_cnt_reg >= 32'(PUP_CYCLES - 1)) state_reg <= sac_pkg::ST_RUN;
               else pup_cnt_reg <= pup_cnt_reg + 32'h0000_0001;
            end
            sac_pkg::ST_RUN: begin
               if (soft_req) state_reg <= sac_pkg::ST_SOFT;
            end
            sac_pkg::ST_SOFT: begin
               pup_cnt_reg <= 32'h0000_0000;
               state_reg <= sac_pkg::ST_WAIT;
            end
            default: state_reg <= sac_pkg::ST_WAIT;
         endcase
      end
   end
   logic running;
   assign running = (state_reg == sac_pkg::ST_RUN);

   // ------------------------------------------------------------
   // Serial shift register and chain output
   // ------------------------------------------------------------
   logic [5:0] shift_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) shift_reg <= sac_pkg::REF_WORD;
      else if (mode_s && sclk_rise && !le_s)
         shift_reg <= {shift_reg[4:0], sdi_s};
   end
   // Chain output is bit5, i.e. the input six shift clocks ago
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) serial_chain_out <= 1'b0;
      else serial_chain_out <= shift_reg[sac_pkg::MSB];
   end

   // ------------------------------------------------------------
   // Active attenuation word
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) atten_word <= sac_pkg::REF_WORD;
      else if (state_reg == sac_pkg::ST_WAIT) begin
         if (pup_cnt_reg >= 32'(PUP_CYCLES - 1)) begin
            if (le_s) atten_word <= par_s;
            else atten_word <= pup_word(pa_s, sel_b2_reg);
         end
      end else if (running) begin
         if (mode_s) begin
            if (le_rise) atten_word <= shift_reg;
         end else if (le_s) begin
            atten_word <= par_s;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) atten_valid <= 1'b0;
      else atten_valid <= running;
   end

   // ------------------------------------------------------------
   // APB slave: ctrl (soft re-power-up), status
   // ------------------------------------------------------------
   logic wr_hit;
   assign wr_hit = psel && penable && pwrite && (paddr == sac_pkg::OFF_CTRL);
   assign soft_req = wr_hit && pwdata[sac_pkg::CTRL_SOFT];
   // No wait states: every access completes in its access cycle
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Status: word in bits 5:0, running bit 8, serial mode bit 9
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= sac_pkg::RD_ZERO;
      else if (psel && !penable && !pwrite) begin
         if (paddr == sac_pkg::OFF_STAT)
            prdata <= {22'h000000, mode_s, running, 2'h0, atten_word};
         else prdata <= sac_pkg::RD_ZERO;
      end
   end

   // ------------------------------------------------------------
   // Check helpers
   // ------------------------------------------------------------
   // Counts cycles spent waiting, so the capture delay is checked
   // without a long repetition in a property
   logic [31:0] wait_len_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_len_reg <= 32'h0000_0000;
      end else if (state_reg == sac_pkg::ST_WAIT) begin
         wait_len_reg <= wait_len_reg + 32'h0000_0001;
      end else begin
         wait_len_reg <= 32'h0000_0000;
      end
   end
   logic pup_last;
   assign pup_last = (state_reg == sac_pkg::ST_WAIT) && (pup_cnt_reg >= 32'(PUP_CYCLES - 1));
   logic stat_rd;
   assign stat_rd = psel && !penable && !pwrite;

   // ------------------------------------------------------------
   // Checks: serial path
   // ------------------------------------------------------------
   a_shift_hold: assert property (@(posedge pclk) disable iff (!presetn)
      le_s |=> $stable(shift_reg))
      else $error("shift moved with strobe high");

   a_shift_in: assert property (@(posedge pclk) disable iff (!presetn)
      mode_s && sclk_rise && !le_s |=> shift_reg[0] == $past(sdi_s))
      else $error("bit not shifted in");

   a_shift_order: assert property (@(posedge pclk) disable iff (!presetn)
      mode_s && sclk_rise && !le_s |=> shift_reg[5:1] == $past(shift_reg[4:0]))
      else $error("shift order wrong");

   a_shift_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !(mode_s && sclk_rise && !le_s) |=> $stable(shift_reg))
      else $error("shift without clock edge");

   a_chain_out: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> serial_chain_out == $past(shift_reg[5]))
      else $error("chain out wrong");

   a_serial_latch: assert property (@(posedge pclk) disable iff (!presetn)
      running && mode_s && le_rise && !soft_req |=> atten_word == $past(shift_reg))
      else $error("serial latch missed");

   a_serial_only: assert property (@(posedge pclk) disable iff (!presetn)
      running && mode_s && !le_rise |=> $stable(atten_word))
      else $error("serial word changed without strobe");

   // ------------------------------------------------------------
   // Checks: parallel path and power-up
   // ------------------------------------------------------------
   a_direct_par: assert property (@(posedge pclk) disable iff (!presetn)
      running && !mode_s && le_s && !soft_req |=> atten_word == $past(par_s))
      else $error("direct parallel not followed");

   a_par_hold: assert property (@(posedge pclk) disable iff (!presetn)
      running && !mode_s && !le_s && !soft_req |=> $stable(atten_word))
      else $error("latched word changed");

   // Select pins are sampled only on the last waiting cycle
   a_pup_sel: assert property (@(posedge pclk) disable iff (!presetn)
      pup_last && !le_s
      |=> atten_word == pup_word($past(pa_s), $past(sel_b2_reg)))
      else $error("power-up select wrong");

   a_pup_par: assert property (@(posedge pclk) disable iff (!presetn)
      pup_last && le_s |=> atten_word == $past(par_s))
      else $error("power-up parallel wrong");

   a_pup_wait: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == sac_pkg::ST_WAIT |-> atten_valid == 1'b0 || $past(running))
      else $error("valid before power-up capture");

   a_pup_count: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == sac_pkg::ST_WAIT && !pup_last |=> pup_cnt_reg == $past(pup_cnt_reg) + 32'h1)
      else $error("power-up count skipped");

   a_word_settle: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == sac_pkg::ST_WAIT && !pup_last |=> $stable(atten_word))
      else $error("word changed while waiting");

   a_capture_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(running) |-> wait_len_reg == 32'(PUP_CYCLES))
      else $error("capture delay wrong");

   a_valid_follow: assert property (@(posedge pclk) disable iff (!presetn)
      running |=> atten_valid)
      else $error("valid not raised");

   a_soft_enter: assert property (@(posedge pclk) disable iff (!presetn)
      running && soft_req |=> state_reg == sac_pkg::ST_SOFT)
      else $error("restart request lost");

   a_soft_rearm: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == sac_pkg::ST_SOFT |=> state_reg == sac_pkg::ST_WAIT && pup_cnt_reg == 32'h0)
      else $error("restart did not rearm wait");

   a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> $onehot(state_reg))
      else $error("state code not one-hot");

   // ------------------------------------------------------------
   // Checks: register bus
   // ------------------------------------------------------------
   a_status_word: assert property (@(posedge pclk) disable iff (!presetn)
      stat_rd && paddr == sac_pkg::OFF_STAT |=> prdata[5:0] == $past(atten_word))
      else $error("status word wrong");

   a_status_empty: assert property (@(posedge pclk) disable iff (!presetn)
      stat_rd && paddr != sac_pkg::OFF_STAT |=> prdata == sac_pkg::RD_ZERO)
      else $error("unmapped read not zero");
endmodule // sac_top

/* testbench/sac_ctl_model.sv */
`timescale 1ns/1ns
module sac_ctl_model (
   input wire logic pclk,
   input wire logic serial_chain_out,
   output logic shift_clk,
   output logic serial_word_in,
   output logic latch_strobe
);
   initial begin
      shift_clk = 1'b0;
      serial_word_in = 1'b0;
      latch_strobe = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge pclk);
   endtask
   task automatic set_strobe(input logic v);
      latch_strobe <= v;
      half();
   endtask
   // Clock stands low between frames; data shown inverted once released
   task automatic shift_word(input logic [5:0] w, output logic [5:0] seen);
      for (int i = 5; i >= 0; i--) begin
         serial_word_in <= w[i];
         half();
         seen[i] = serial_chain_out;
         shift_clk <= 1'b1;
         half();
         shift_clk <= 1'b0;
      end
      serial_word_in <= ~w[0];
      half();
   endtask
   task automatic pulse_strobe();
      latch_strobe <= 1'b1;
      half();
      latch_strobe <= 1'b0;
      half();
   endtask
endmodule // sac_ctl_model

/* testbench/step_attenuator_control_bench.sv */
`timescale 1ns/1ns
module step_attenuator_control_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, serial_mode = 1'b0, shift_clk, serial_word_in, latch_strobe;
   logic [5:0] par = 6'h2a, atten_word, seen;
   logic sel_a = 1'b0, sel_b = 1'b0, serial_chain_out, atten_valid;
   logic e = 1'b0;
   int errors = 0, total_checks = 0;
   localparam int PUP = 20;
   always #20 pclk = ~pclk;
   sac_top #(.PUP_CYCLES(PUP)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_mode(serial_mode), .shift_clk(shift_clk),
      .serial_word_in(serial_word_in), .latch_strobe(latch_strobe),
      .parallel_weight_inputs(par), .powerup_select_a(sel_a), .powerup_select_b(sel_b),
      .serial_chain_out(serial_chain_out), .atten_word(atten_word), .atten_valid(atten_valid));
   sac_ctl_model u_ctl (.pclk(pclk), .serial_chain_out(serial_chain_out),
      .shift_clk(shift_clk), .serial_word_in(serial_word_in), .latch_strobe(latch_strobe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Power-on: reset doubles as supply ramp
   task automatic por(input logic a, input logic b, input logic s);
      presetn <= 1'b0;
      sel_a <= a;
      sel_b <= b;
      u_ctl.set_strobe(s);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, atten_valid}, 32'h0);
      repeat (PUP + 8) @(posedge pclk);
      chk({31'h0, atten_valid}, 32'h1);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      print_verdict();
   end
   initial begin
      int steps[4] = '{63, 48, 32, 0};
      for (int i = 0; i < 4; i++) begin
         por(i[0], i[1], 1'b0);
         chk({26'h0, atten_word}, {26'h0, ~steps[i][5:0]});
      end
      par <= 6'h15;
      por(1'b0, 1'b0, 1'b1);
      chk({26'h0, atten_word}, 32'h15);
      $display("power-up test done");
      for (int k = 0; k <= 6; k++) begin
         par <= (k == 6) ? 6'h12 : ~(6'h01 << k);
         repeat (6) @(posedge pclk);
         chk({26'h0, atten_word}, (k == 6) ? 32'h12 : {26'h0, ~(6'h01 << k)});
      end
      u_ctl.set_strobe(1'b0);
      par <= 6'h33;
      repeat (8) @(posedge pclk);
      chk({26'h0, atten_word}, 32'h12);
      u_ctl.pulse_strobe();
      par <= 6'h0c;
      repeat (8) @(posedge pclk);
      chk({26'h0, atten_word}, 32'h33);
      $display("parallel test done");
      serial_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      u_ctl.shift_word(6'h2a, seen);
      u_ctl.shift_word(6'h15, seen);
      chk({26'h0, seen}, 32'h2a);
      chk({26'h0, atten_word}, 32'h33);
      u_ctl.pulse_strobe();
      chk({26'h0, atten_word}, 32'h15);
      // Strobe high masks the shift clock, parallel pins ignored here
      u_ctl.set_strobe(1'b1);
      u_ctl.shift_word(6'h3c, seen);
      u_ctl.set_strobe(1'b0);
      u_ctl.pulse_strobe();
      chk({26'h0, atten_word}, 32'h15);
      $display("serial test done");
      apb(1'b0, sac_pkg::OFF_STAT, 32'h0);
      chk(d & 32'h0000_033f, 32'h0000_0315);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h0);
      apb(1'b1, sac_pkg::OFF_CTRL, 32'h0000_0040);
      repeat (2) @(posedge pclk);
      chk({31'h0, atten_valid}, 32'h0);
      repeat (PUP + 8) @(posedge pclk);
      chk({31'h0, atten_valid}, 32'h1);
      chk({26'h0, atten_word}, 32'h00);
      $display("register test done");
      print_verdict();
   end
endmodule // step_attenuator_control_bench
